// [rtl/wdit_edge.sv]
// Edge detector turning a synchronised slow clock level into a one-cycle tick
module wdit_edge
  import wdit_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Source level
  input  wire logic level_in,
  // Tick
  output logic      rise_pulse
);

  logic sync1_q, sync2_q, last_q;
  logic sync1_d, sync2_d, last_d;

  always_comb begin
    sync1_d = level_in;
    sync2_d = sync1_q;
    last_d  = sync2_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      last_q  <= last_d;
    end
  end

  assign rise_pulse = sync2_q & ~last_q;

endmodule : wdit_edge

// [rtl/wdit_pkg.sv]
// Package: register map, field layout, reset values and feed constants of the watchdog
package wdit_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] WDIT_OFS_CTRL   = 4'h0;  // watchdog_control_reg
  localparam logic [3:0] WDIT_OFS_RELOAD = 4'h1;
  localparam logic [3:0] WDIT_OFS_FEED   = 4'h2;
  localparam logic [3:0] WDIT_OFS_COUNT  = 4'h3;
  localparam logic [3:0] WDIT_OFS_STATUS = 4'h4;
  localparam logic [3:0] WDIT_OFS_MASK   = 4'h5;

  // ------------------------------------------------------------
  // Control field layout
  // ------------------------------------------------------------
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_WDRE_BIT  = 1;  // watchdog_reset_enable
  localparam int CTRL_SRC_LSB   = 2;  // 2 bits
  localparam int CTRL_TAP_LSB   = 4;  // 3 bits

  // ------------------------------------------------------------
  // Status bits
  // ------------------------------------------------------------
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_BADFEED_BIT = 1;

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int          WDIT_PRE_W    = 12;
  localparam int          WDIT_CNT_W    = 8;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  RELOAD_RST    = 8'hFF;
  localparam logic [1:0]  MASK_RST      = 2'h0;

  // ------------------------------------------------------------
  // Feed bytes and reset pulse length
  // ------------------------------------------------------------
  localparam logic [7:0]  FEED_BYTE_1   = 8'hA5;
  localparam logic [7:0]  FEED_BYTE_2   = 8'h5A;
  localparam int          RST_PULSE_CYC = 4;

  typedef enum logic [1:0] {SRC_PCLK, SRC_WDOSC, SRC_XTAL} wdit_src_t;
  typedef enum logic [1:0] {FEED_IDLE, FEED_HALF, FEED_CTRL} wdit_feed_t;

endpackage : wdit_pkg

// [rtl/wdit_prescaler.sv]
// 12-bit prescaler with selectable tap, gives one tick per tap carry
module wdit_prescaler
  import wdit_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       src_tick,
  input  wire logic       clear,
  input  wire logic [2:0] tap_sel,
  // Tap output
  output logic            tap_pulse
);

  logic [WDIT_PRE_W-1:0] pre_q, pre_d;
  logic [WDIT_PRE_W-1:0] tap_mask;

  // Tap n counts 2^(5+n) source ticks; largest tap uses the full 12 bits
  always_comb begin
    tap_mask = WDIT_PRE_W'((13'h0020 << tap_sel) - 13'h0001);
    pre_d    = pre_q;
    if (clear) begin
      pre_d = '0;
    end else if (src_tick) begin
      pre_d = pre_q + 12'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  assign tap_pulse = src_tick & ~clear & ((pre_q & tap_mask) == tap_mask);

endmodule : wdit_prescaler

// [rtl/wdit_top.sv]
// Watchdog and interval timer: register port, feed checker, down counter, reset and interrupt

// Operation
// RULE1 - In watchdog mode an underflow of the unfed down counter pulses the system reset.
// RULE2 - The timing chain is a 12-bit prescaler feeding an 8-bit down counter.
// RULE3 - The down counter steps once per pulse from the selected prescaler tap.
// RULE4 - The prescaler source is the peripheral clock, watchdog oscillator or slow crystal.
// RULE5 - Only power-on reset clears the block; other system resets leave it alone.
// RULE6 - With reset disabled the block is an interval timer raising an interrupt on time-out.
// RULE7 - Software feeds with two consecutive writes of the two feed bytes, in order.
// RULE8 - With the peripheral clock selected and the processor powered down, counting stops.
// RULE9 - A wrong feed value or order causes a watchdog reset.
// RULE10 - A control write not immediately followed by a valid feed causes a watchdog reset.
// RULE11 - The reset-enable bit at one selects watchdog mode, zero selects the interval timer.
// RULE12 - A valid feed reloads the counter, clears the prescaler and commits a pending control.
// RULE13 - The feed bytes are distinct non-zero constants.
module wdit_top
  import wdit_pkg::*;
(
  // Clock and power-on reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Clock sources, levels of the slow clocks
  input  wire logic       wdosc_clk_lvl,
  input  wire logic       xtal_clk_lvl,
  input  wire logic       cpu_power_down,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // System outputs
  output logic            wd_reset_out,
  output logic            irq
);

  // ------------------------------------------------------------
  // Clock source selection
  // ------------------------------------------------------------
  logic wdosc_tick, xtal_tick, src_tick, tap_pulse, pre_clear;
  logic [7:0] ctrl_q, ctrl_d;

  wdit_edge u_wdosc (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .level_in   (wdosc_clk_lvl),
    .rise_pulse (wdosc_tick)
  );

  wdit_edge u_xtal (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .level_in   (xtal_clk_lvl),
    .rise_pulse (xtal_tick)
  );

  logic [1:0] src_sel;
  logic       run_en;

  assign src_sel = ctrl_q[CTRL_SRC_LSB +: 2];

  always_comb begin
    case (src_sel)
      SRC_PCLK:  src_tick = ~cpu_power_down;  // RULE4 RULE8
      SRC_WDOSC: src_tick = wdosc_tick;       // RULE4
      SRC_XTAL:  src_tick = xtal_tick;        // RULE4
      default:   src_tick = 1'b0;
    endcase
    // Powered down on the peripheral clock counts as disabled
    run_en = ctrl_q[CTRL_RUN_BIT] & ~(src_sel == SRC_PCLK && cpu_power_down);  // RULE8
  end

  wdit_prescaler u_pre (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .src_tick  (src_tick & run_en),
    .clear     (pre_clear),
    .tap_sel   (ctrl_q[CTRL_TAP_LSB +: 3]),
    .tap_pulse (tap_pulse)                    // RULE2 RULE3
  );

  // ------------------------------------------------------------
  // Register and feed state
  // ------------------------------------------------------------
  logic [7:0]             ctrl_pend_q, ctrl_pend_d;
  logic [7:0]             reload_q, reload_d;
  logic [WDIT_CNT_W-1:0]  cnt_q, cnt_d;
  logic [1:0]             stat_q, stat_d;
  logic [1:0]             mask_q, mask_d;
  wdit_feed_t             feed_q, feed_d;
  logic                   feed_ctrl_q, feed_ctrl_d;
  logic [2:0]             rst_cnt_q, rst_cnt_d;
  logic [7:0]             rdata_q, rdata_d;
  logic                   valid_feed, bad_feed, underflow, fire_reset;

  wire wr_ctrl   = reg_wr && reg_addr == WDIT_OFS_CTRL;
  wire wr_feed   = reg_wr && reg_addr == WDIT_OFS_FEED;
  wire wr_reload = reg_wr && reg_addr == WDIT_OFS_RELOAD;
  wire wr_stat   = reg_wr && reg_addr == WDIT_OFS_STATUS;
  wire wr_mask   = reg_wr && reg_addr == WDIT_OFS_MASK;

  // ------------------------------------------------------------
  // Feed sequence checker
  // ------------------------------------------------------------
  // Any register write between the two feed bytes breaks the pair, so a
  // stray write during the sequence is caught rather than ignored.
  always_comb begin
    feed_d      = feed_q;
    feed_ctrl_d = feed_ctrl_q;
    ctrl_pend_d = ctrl_pend_q;
    valid_feed  = 1'b0;
    bad_feed    = 1'b0;
    case (feed_q)
      FEED_IDLE: begin
        if (wr_feed) begin
          if (reg_wdata == FEED_BYTE_1) begin
            feed_d = FEED_HALF;           // RULE7 RULE13
          end else begin
            bad_feed = 1'b1;              // RULE9
          end
        end else if (wr_ctrl) begin
          ctrl_pend_d = reg_wdata;
          feed_d      = FEED_CTRL;
        end
      end
      FEED_CTRL: begin
        // The very next write must open a feed
        if (reg_wr) begin
          if (wr_feed && reg_wdata == FEED_BYTE_1) begin
            feed_d      = FEED_HALF;
            feed_ctrl_d = 1'b1;
          end else begin
            bad_feed = 1'b1;              // RULE10
            feed_d   = FEED_IDLE;
          end
        end
      end
      FEED_HALF: begin
        if (reg_wr) begin
          feed_d      = FEED_IDLE;
          feed_ctrl_d = 1'b0;
          if (wr_feed && reg_wdata == FEED_BYTE_2) begin
            valid_feed = 1'b1;            // RULE7 RULE13
          end else begin
            bad_feed = 1'b1;              // RULE9 RULE10
          end
        end
      end
      default: begin
        feed_d = FEED_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Counter, registers, reset and interrupt
  // ------------------------------------------------------------
  always_comb begin
    ctrl_d    = ctrl_q;
    reload_d  = reload_q;
    cnt_d     = cnt_q;
    mask_d    = mask_q;
    pre_clear = 1'b0;
    underflow = 1'b0;
    if (wr_reload) begin
      reload_d = reg_wdata;
    end
    if (wr_mask) begin
      mask_d = reg_wdata[1:0];
    end
    if (valid_feed) begin
      cnt_d     = reload_q;               // RULE12
      pre_clear = 1'b1;                   // RULE12
      if (feed_ctrl_q) begin
        ctrl_d = ctrl_pend_q;             // RULE12
      end
    end else if (tap_pulse && run_en) begin
      if (cnt_q == '0) begin
        underflow = 1'b1;
        cnt_d     = reload_q;
      end else begin
        cnt_d = cnt_q - 8'h01;            // RULE3
      end
    end
    fire_reset = bad_feed | (underflow & ctrl_q[CTRL_WDRE_BIT]);  // RULE1 RULE9 RULE11
    // Set wins over a write-one clear in the same cycle
    stat_d = stat_q & ~(wr_stat ? reg_wdata[1:0] : 2'b00);
    if (underflow && !ctrl_q[CTRL_WDRE_BIT]) begin
      stat_d[STAT_TIMEOUT_BIT] = 1'b1;    // RULE6 RULE11
    end
    if (bad_feed) begin
      stat_d[STAT_BADFEED_BIT] = 1'b1;
    end
    if (fire_reset) begin
      rst_cnt_d = 3'(RST_PULSE_CYC);
    end else if (rst_cnt_q != 3'd0) begin
      rst_cnt_d = rst_cnt_q - 3'd1;
    end else begin
      rst_cnt_d = rst_cnt_q;
    end
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        WDIT_OFS_CTRL:   rdata_d = ctrl_q;
        WDIT_OFS_RELOAD: rdata_d = reload_q;
        WDIT_OFS_COUNT:  rdata_d = cnt_q;
        WDIT_OFS_STATUS: rdata_d = {6'h00, stat_q};
        WDIT_OFS_MASK:   rdata_d = {6'h00, mask_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  // Only the power-on reset reaches these flops; the watchdog's own reset
  // output goes to the rest of the system, not back here.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin                     // RULE5
      ctrl_q      <= CTRL_RST;
      ctrl_pend_q <= CTRL_RST;
      reload_q    <= RELOAD_RST;
      cnt_q       <= RELOAD_RST;
      stat_q      <= 2'b00;
      mask_q      <= MASK_RST;
      feed_q      <= FEED_IDLE;
      feed_ctrl_q <= 1'b0;
      rst_cnt_q   <= 3'd0;
      rdata_q     <= 8'h00;
    end else begin
      ctrl_q      <= ctrl_d;
      ctrl_pend_q <= ctrl_pend_d;
      reload_q    <= reload_d;
      cnt_q       <= cnt_d;
      stat_q      <= stat_d;
      mask_q      <= mask_d;
      feed_q      <= feed_d;
      feed_ctrl_q <= feed_ctrl_d;
      rst_cnt_q   <= rst_cnt_d;
      rdata_q     <= rdata_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign wd_reset_out = rst_cnt_q != 3'd0;  // RULE1
  assign irq          = |(stat_q & mask_q); // RULE6

endmodule : wdit_top

// [verif/test_watchdog_interval_timer.sv]
// Testbench: self-checking bench of the watchdog and interval timer
module test_watchdog_interval_timer
  import wdit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wdosc_clk_lvl = 1'b0;
  logic       xtal_clk_lvl = 1'b0;
  logic       cpu_power_down = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       wd_reset_out;
  logic       irq;
  logic [7:0] d, r, s, c;
  logic       seen;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  logic [3:0] ta [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'hF};
  logic [7:0] te [6] = '{CTRL_RST, RELOAD_RST, RELOAD_RST, 8'h00, 8'h00, 8'h00};

  always #2.5 ref_clk = ~ref_clk;

  // Slow sources run free; their phase against a feed is deliberately arbitrary
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    wdosc_clk_lvl <= cyc[2];
    xtal_clk_lvl <= (cyc % 12) < 6;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  wdit_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wdosc_clk_lvl(wdosc_clk_lvl),
    .xtal_clk_lvl(xtal_clk_lvl), .cpu_power_down(cpu_power_down), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wd_reset_out(wd_reset_out), .irq(irq));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle

  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
    chk(d, e);
  endtask : rdchk

  task automatic feed();
    wr(WDIT_OFS_FEED, FEED_BYTE_1);
    wr(WDIT_OFS_FEED, FEED_BYTE_2);
    idle(1);
  endtask : feed

  // Checks whether the reset output was seen high within n cycles
  task automatic wait_rst(input int n, input logic e);
    idle(0);
    seen = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      if (wd_reset_out === 1'b1)
        seen = 1'b1;
    end
    chk({7'h00, seen}, {7'h00, e});
  endtask : wait_rst

  task automatic tend(input string n);
    $display("test %s done", n);
  endtask : tend

  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({7'h00, FEED_BYTE_1 != FEED_BYTE_2 && FEED_BYTE_1 != 0 && FEED_BYTE_2 != 0}, 8'h01);
    for (int i = 0; i < 6; i++)
      rdchk(ta[i], te[i]);
    wr(WDIT_OFS_COUNT, 8'h12);
    wr(4'hF, 8'h34);
    rdchk(WDIT_OFS_COUNT, RELOAD_RST);
    tend("reset");
    s = 8'h52;
    for (int t = 0; t < 3; t++) begin
      s = lfsr(s);
      r = {4'h1, s[3:0]};
      wr(WDIT_OFS_RELOAD, r);
      wr(WDIT_OFS_CTRL, {1'b0, 3'(t), 4'h1});
      feed();
      rdchk(WDIT_OFS_COUNT, r);
      idle(5 << (4 + t));
      rdchk(WDIT_OFS_COUNT, r - 8'h02);
    end
    tend("taps");
    cpu_power_down <= 1'b1;
    idle(2);
    rdchk(WDIT_OFS_COUNT, r - 8'h02);
    c = d;
    idle(300);
    rdchk(WDIT_OFS_COUNT, c);
    cpu_power_down <= 1'b0;
    tend("power");
    // Top tap spans the full 12-bit prescaler: one step per 4096 ticks
    wr(WDIT_OFS_CTRL, 8'h71);
    feed();
    idle(4100);
    rdchk(WDIT_OFS_COUNT, r - 8'h01);
    tend("tap7");
    for (int k = 1; k < 3; k++) begin
      wr(WDIT_OFS_RELOAD, r);
      wr(WDIT_OFS_CTRL, {4'h0, 2'(k), 2'b01});
      feed();
      idle(600);
      rdchk(WDIT_OFS_COUNT, r - 8'(3 - k));
    end
    tend("source");
    wr(WDIT_OFS_RELOAD, 8'h02);
    wr(WDIT_OFS_CTRL, 8'h01);
    feed();
    wr(WDIT_OFS_MASK, 8'h01);
    wait_rst(130, 1'b0);
    chk({7'h00, irq}, 8'h01);
    wr(WDIT_OFS_CTRL, 8'h00);
    feed();
    rdchk(WDIT_OFS_STATUS, 8'h01);
    wr(WDIT_OFS_STATUS, 8'h01);
    idle(1);
    chk({7'h00, irq}, 8'h00);
    tend("interval");
    wr(WDIT_OFS_CTRL, 8'h03);
    feed();
    wait_rst(150, 1'b1);
    rdchk(WDIT_OFS_CTRL, 8'h03);
    rdchk(WDIT_OFS_STATUS, 8'h00);
    wr(WDIT_OFS_CTRL, 8'h00);
    feed();
    idle(8);
    tend("watchdog");
    wr(WDIT_OFS_MASK, 8'h02);
    for (int b = 0; b < 3; b++) begin
      case (b)
        0: wr(WDIT_OFS_FEED, FEED_BYTE_2);
        1: begin
          wr(WDIT_OFS_CTRL, 8'h00);
          wr(WDIT_OFS_RELOAD, 8'h02);
        end
        default: begin
          wr(WDIT_OFS_FEED, FEED_BYTE_1);
          wr(WDIT_OFS_MASK, 8'h02);
        end
      endcase
      wait_rst(6, 1'b1);
      chk({7'h00, irq}, 8'h01);
      wr(WDIT_OFS_STATUS, 8'h02);
      idle(1);
      chk({7'h00, irq}, 8'h00);
    end
    tend("badfeed");
    print_verdict();
  end
endmodule : test_watchdog_interval_timer

// [verif/wdit_top_asserts.sv]
// Checker: port-level properties of the watchdog and interval timer
module wdit_top_asserts
  import wdit_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // System outputs
  input wire logic       wd_reset_out,
  input wire logic       irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------
  // Shadows of the plain read/write registers
  // --------------------------------------------------------
  logic [7:0] reload_q;
  logic [1:0] mask_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= RELOAD_RST;
      mask_q   <= MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == WDIT_OFS_RELOAD)
        reload_q <= reg_wdata;
      if (reg_addr == WDIT_OFS_MASK)
        mask_q <= reg_wdata[1:0];
    end
  end

  sequence ctrl_wr_s;
    reg_wr && reg_addr == WDIT_OFS_CTRL;
  endsequence
  sequence feed1_s;
    reg_wr && reg_addr == WDIT_OFS_FEED && reg_wdata == FEED_BYTE_1;
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  reload_read_a: assert property (reg_rd && reg_addr == WDIT_OFS_RELOAD
    |=> reg_rdata == $past(reload_q)) else $error("reload read wrong");
  mask_read_a: assert property (reg_rd && reg_addr == WDIT_OFS_MASK
    |=> reg_rdata == {6'h00, $past(mask_q)}) else $error("mask read wrong");
  unmapped_rd_a: assert property (reg_rd && reg_addr > WDIT_OFS_MASK
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  irq_masked_a: assert property (mask_q == 2'h0 |-> !irq)
    else $error("interrupt while fully masked");
  ctrl_nofeed_a: assert property (ctrl_wr_s ##1 (reg_wr && reg_addr != WDIT_OFS_FEED)
    |=> wd_reset_out) else $error("no reset after unfed control write");
  feed_order_a: assert property (feed1_s ##1 (reg_wr && (reg_addr != WDIT_OFS_FEED
    || reg_wdata != FEED_BYTE_2)) |=> wd_reset_out) else $error("no reset on bad feed");
  rst_pulse_a: assert property ($rose(wd_reset_out) |-> wd_reset_out[*4])
    else $error("reset pulse too short");
endmodule : wdit_top_asserts

bind wdit_top wdit_top_asserts i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wd_reset_out(wd_reset_out), .irq(irq));
